// file: dsc_pkg.sv
// package for the distribution source configuration block
// assumes an AXI4-Lite register bus with 32-bit data
package dsc_pkg;
  // register indices; one aligned word each, byte address is four times the index
  localparam logic [9:0] IDX_PLL_CTRL = 10'h010;
  localparam logic [9:0] IDX_VCO_DIV = 10'h1E0;
  localparam logic [9:0] IDX_DIST_SRC = 10'h1E1;
  localparam logic [9:0] IDX_NV_CTRL = 10'h1F0;
  localparam logic [9:0] IDX_STATUS = 10'h1F4;
  // register byte addresses
  localparam logic [11:0] ADDR_PLL_CTRL = {IDX_PLL_CTRL, 2'h0};
  localparam logic [11:0] ADDR_VCO_DIV = {IDX_VCO_DIV, 2'h0};
  localparam logic [11:0] ADDR_DIST_SRC = {IDX_DIST_SRC, 2'h0};
  localparam logic [11:0] ADDR_NV_CTRL = {IDX_NV_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  // field positions
  localparam int PLL_PWR_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int BYPASS_BIT = 0;
  localparam int SRC_SEL_BIT = 1;
  localparam int NV_SAVE_BIT = 0;
  localparam int NV_LOAD_BIT = 1;
  // field codes
  localparam logic [1:0] PLL_PWR_ON = 2'h0;
  localparam logic [1:0] PLL_PWR_DOWN = 2'h1;
  localparam logic [2:0] VCO_DIV_BY2 = 3'h0;
  localparam logic [2:0] VCO_DIV_MAX_CODE = 3'h5;
  // reset values
  localparam logic [7:0] RST_PLL_CTRL = 8'h01;
  localparam logic [7:0] RST_VCO_DIV = 8'h00;
  localparam logic [7:0] RST_DIST_SRC = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NV_WIDTH = 24;
  typedef enum logic [1:0] {NV_IDLE, NV_SAVE, NV_LOAD} dsc_nv_state_t;
endpackage

// file: dsc_nvstore.sv
// nonvolatile image of the configuration registers
// assumes a storage whose image survives RST; RST clears its valid flag
`timescale 1ns/10ps
`default_nettype none
module dsc_nvstore
  import dsc_pkg::*;
#(
  parameter int W = NV_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic save,
  input wire logic [W-1:0] save_data,
  output logic valid,
  output logic [W-1:0] image
);
  logic [W-1:0] image_r;
  logic valid_r;
  // stored image is not touched by reset
  always_ff @(posedge clk) begin
    if (save) begin
      image_r <= save_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else if (save) begin
      valid_r <= 1'b1;
    end
  end
  assign valid = valid_r;
  assign image = image_r;
endmodule
`default_nettype wire

// file: dsc_top.sv
// distribution source configuration with an AXI4-Lite slave
// assumes a single 100 MHz clock and external vco or clock source
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - power field 01b downs pll, 00b runs
// - bypass bit routes source around vco divider
// - source bit 0 selects differential clock input
// - polarity bit 0 positive, 1 negative
// - reset: pll down, divider used, by two
// - pll on with source bit 0 feeds vco into prescaler
// - configuration saves to nonvolatile storage
module dsc_top
  import dsc_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // axi4-lite write
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // clock path controls
  output logic PLL_POWER_DOWN,
  output logic PFD_POLARITY_NEG,
  output logic VCO_DIV_BYPASS,
  output logic SRC_SEL_CLK_INPUT,
  output logic [2:0] VCO_DIV_RATIO_M1,
  output logic PRESCALER_FROM_EXT_VCO
);
  logic [7:0] pll_ctrl_r;
  logic [7:0] vco_div_r;
  logic [7:0] dist_src_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic nv_save_r;
  logic load_done_r;
  dsc_nv_state_t nv_state_r;
  logic pll_down_r;
  logic pfd_neg_r;
  logic bypass_r;
  logic src_clk_r;
  logic [2:0] div_m1_r;
  logic presc_ext_r;
  logic nv_valid;
  logic [NV_WIDTH-1:0] nv_image;

  // address decode
  function automatic logic known_addr(input logic [11:0] a);
    return (a == ADDR_PLL_CTRL) || (a == ADDR_VCO_DIV) || (a == ADDR_DIST_SRC)
      || (a == ADDR_NV_CTRL) || (a == ADDR_STATUS);
  endfunction

  wire aw_take = S_AXI_AWVALID && awready_r;
  wire w_take = S_AXI_WVALID && wready_r;
  wire aw_now = aw_have_r || aw_take;
  wire w_now = w_have_r || w_take;
  wire [11:0] wr_addr = aw_take ? S_AXI_AWADDR : awaddr_r;
  wire [31:0] wr_data = w_take ? S_AXI_WDATA : wdata_r;
  wire [3:0] wr_strb = w_take ? S_AXI_WSTRB : wstrb_r;
  wire wr_go = aw_now && w_now && !bvalid_r;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire wr_pll = wr_lane0 && (wr_addr == ADDR_PLL_CTRL);
  wire wr_div = wr_lane0 && (wr_addr == ADDR_VCO_DIV);
  wire wr_src = wr_lane0 && (wr_addr == ADDR_DIST_SRC);
  wire wr_nv = wr_lane0 && (wr_addr == ADDR_NV_CTRL);
  wire [1:0] wr_resp = known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
  wire [NV_WIDTH-1:0] nv_save_data = {dist_src_r, vco_div_r, pll_ctrl_r};
  wire do_load = nv_state_r == NV_LOAD;

  // write channel
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_take) begin
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        awready_r <= 1'b0;
        wready_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_resp;
      end else begin
        aw_have_r <= aw_now;
        w_have_r <= w_now;
        awready_r <= !aw_now && !bvalid_r;
        wready_r <= !w_now && !bvalid_r;
        if (bvalid_r && S_AXI_BREADY) begin
          bvalid_r <= 1'b0;
          awready_r <= 1'b1;
          wready_r <= 1'b1;
        end
      end
    end
  end

  // configuration registers; loaded from storage on request
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pll_ctrl_r <= RST_PLL_CTRL;
      vco_div_r <= RST_VCO_DIV;
      dist_src_r <= RST_DIST_SRC;
    end else if (do_load) begin
      pll_ctrl_r <= nv_image[7:0];
      vco_div_r <= nv_image[15:8];
      dist_src_r <= nv_image[23:16];
    end else begin
      if (wr_pll) begin
        pll_ctrl_r <= wr_data[7:0];
      end
      if (wr_div) begin
        vco_div_r <= wr_data[7:0];
      end
      if (wr_src) begin
        dist_src_r <= wr_data[7:0];
      end
    end
  end

  // save and load sequencing
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      nv_state_r <= NV_IDLE;
      nv_save_r <= 1'b0;
      load_done_r <= 1'b0;
    end else begin
      nv_save_r <= 1'b0;
      unique case (nv_state_r)
        NV_IDLE: begin
          if (wr_nv && wr_data[NV_SAVE_BIT]) begin
            nv_state_r <= NV_SAVE;
            nv_save_r <= 1'b1;
          end else if (wr_nv && wr_data[NV_LOAD_BIT] && nv_valid) begin
            nv_state_r <= NV_LOAD;
          end
        end
        NV_SAVE: begin
          nv_state_r <= NV_IDLE;
        end
        NV_LOAD: begin
          nv_state_r <= NV_IDLE;
          load_done_r <= 1'b1;
        end
      endcase
    end
  end

  dsc_nvstore #(.W(NV_WIDTH)) u_nv (
    .clk(CORE_CLK),
    .rst(RST),
    .save(nv_save_r),
    .save_data(nv_save_data),
    .valid(nv_valid),
    .image(nv_image)
  );

  // read channel
  wire [7:0] status_byte = {4'h0, load_done_r, nv_valid, nv_state_r};
  wire [7:0] rd_byte =
    (S_AXI_ARADDR == ADDR_PLL_CTRL) ? pll_ctrl_r :
    (S_AXI_ARADDR == ADDR_VCO_DIV) ? vco_div_r :
    (S_AXI_ARADDR == ADDR_DIST_SRC) ? dist_src_r :
    (S_AXI_ARADDR == ADDR_STATUS) ? status_byte : 8'h00;
  wire ar_take = S_AXI_ARVALID && arready_r;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= known_addr(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // clock path decode
  wire [1:0] pwr_field = pll_ctrl_r[PLL_PWR_LSB +: 2];
  wire [2:0] div_code = vco_div_r[2:0];
  wire [2:0] div_m1 = (div_code > VCO_DIV_MAX_CODE) ? 3'h1 :
    ((div_code == VCO_DIV_BY2) ? 3'h1 :
    ((div_code == 3'h1) ? 3'h0 : div_code));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pll_down_r <= 1'b1;
      pfd_neg_r <= 1'b0;
      bypass_r <= 1'b0;
      src_clk_r <= 1'b1;
      div_m1_r <= 3'h1;
      presc_ext_r <= 1'b0;
    end else begin
      pll_down_r <= pwr_field != PLL_PWR_ON;
      pfd_neg_r <= pll_ctrl_r[PFD_POL_BIT];
      bypass_r <= dist_src_r[BYPASS_BIT];
      src_clk_r <= !dist_src_r[SRC_SEL_BIT];
      div_m1_r <= div_m1;
      presc_ext_r <= (pwr_field == PLL_PWR_ON) && !dist_src_r[SRC_SEL_BIT];
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign PLL_POWER_DOWN = pll_down_r;
  assign PFD_POLARITY_NEG = pfd_neg_r;
  assign VCO_DIV_BYPASS = bypass_r;
  assign SRC_SEL_CLK_INPUT = src_clk_r;
  assign VCO_DIV_RATIO_M1 = div_m1_r;
  assign PRESCALER_FROM_EXT_VCO = presc_ext_r;

  // checks
  AST_PWR: assert property (@(posedge CORE_CLK) disable iff (RST)
    PLL_POWER_DOWN == ($past(pwr_field) != PLL_PWR_ON)) else $error("pll power wrong");
  AST_BYP: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(dist_src_r[BYPASS_BIT]) |=> VCO_DIV_BYPASS) else $error("bypass late");
  AST_BYP0: assert property (@(posedge CORE_CLK) disable iff (RST)
    !dist_src_r[BYPASS_BIT] |=> !VCO_DIV_BYPASS) else $error("divider not used");
  AST_SRC: assert property (@(posedge CORE_CLK) disable iff (RST)
    !dist_src_r[SRC_SEL_BIT] |=> SRC_SEL_CLK_INPUT) else $error("source not clk");
  AST_POL: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_pll |-> ##2 PFD_POLARITY_NEG == $past(wr_data[PFD_POL_BIT], 2)) else $error("polarity");
  AST_DIV2: assert property (@(posedge CORE_CLK) disable iff (RST)
    div_code == VCO_DIV_BY2 |=> VCO_DIV_RATIO_M1 == 3'h1) else $error("div code 0");
  AST_DIVN: assert property (@(posedge CORE_CLK) disable iff (RST)
    div_code inside {[3'h2:VCO_DIV_MAX_CODE]} |=> VCO_DIV_RATIO_M1 == $past(div_code))
    else $error("div code ratio");
  AST_RST: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> PLL_POWER_DOWN && !VCO_DIV_BYPASS && VCO_DIV_RATIO_M1 == 3'h1)
    else $error("reset state");
  AST_RSTV: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> SRC_SEL_CLK_INPUT && !PFD_POLARITY_NEG && !PRESCALER_FROM_EXT_VCO)
    else $error("reset outputs");
  AST_PRESC: assert property (@(posedge CORE_CLK) disable iff (RST)
    PRESCALER_FROM_EXT_VCO |-> !PLL_POWER_DOWN) else $error("prescaler feed");
  AST_SAVE: assert property (@(posedge CORE_CLK) disable iff (RST)
    nv_save_r |=> nv_valid ##0 nv_image == $past(nv_save_data)) else $error("save lost");
  AST_LOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
    do_load |=> {dist_src_r, vco_div_r, pll_ctrl_r} == $past(nv_image))
    else $error("load lost");
  AST_WRAK: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_go |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write answer");
  AST_RDZ: assert property (@(posedge CORE_CLK) disable iff (RST)
    ar_take && !known_addr(S_AXI_ARADDR) |=> S_AXI_RDATA == 32'h00000000
    && S_AXI_RRESP == RESP_SLVERR) else $error("unmapped read");
  COV_WR: cover property (@(posedge CORE_CLK) disable iff (RST) wr_go ##1 bvalid_r);
  COV_RD: cover property (@(posedge CORE_CLK) disable iff (RST) ar_take ##1 rvalid_r);
  COV_PLLON: cover property (@(posedge CORE_CLK) disable iff (RST) $fell(PLL_POWER_DOWN));
  COV_LOAD: cover property (@(posedge CORE_CLK) disable iff (RST) do_load);
  COV_SAVE: cover property (@(posedge CORE_CLK) disable iff (RST) nv_save_r);
endmodule
`default_nettype wire

// file: dsc_src_model.sv
// external clock source as seen at the channel dividers
// assumes the block's divider controls drive it
`timescale 1ns/10ps
`default_nettype none
module dsc_src_model #(
  parameter int SRC_MHZ = 2000
) (
  // divider controls
  input wire logic bypass,
  input wire logic [2:0] ratio_m1,
  // channel divider input within limit
  output logic dist_ok
);
  assign dist_ok = SRC_MHZ <= 1600 * (bypass ? 1 : int'(ratio_m1) + 1);
endmodule
`default_nettype wire

// file: dsc_top_bench.sv
// self-checking bench for the distribution source configuration
// assumes an axi4-lite master here and the source model on the divider
`timescale 1ns/10ps
`default_nettype none
module dsc_top_bench import dsc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pd, pol, byp, sel, pre, ok;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0] rat;
  logic [7:0] mdl [logic [11:0]];
  logic [7:0] snap [logic [11:0]];
  int fails = 0;
  int tests_run = 0;
  dsc_top dut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PLL_POWER_DOWN(pd), .PFD_POLARITY_NEG(pol), .VCO_DIV_BYPASS(byp),
    .SRC_SEL_CLK_INPUT(sel), .VCO_DIV_RATIO_M1(rat), .PRESCALER_FROM_EXT_VCO(pre));
  dsc_src_model #(.SRC_MHZ(2000)) src (.bypass(byp), .ratio_m1(rat), .dist_ok(ok));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
    int n;
    logic m;
    n = 0;
    m = a inside {ADDR_PLL_CTRL, ADDR_VCO_DIV, ADDR_DIST_SRC, ADDR_NV_CTRL};
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'($urandom()), v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) fails++;
    chk("bresp", {30'h0, r}, {30'h0, m ? RESP_OKAY : RESP_SLVERR});
    if (m && s[0] && a != ADDR_NV_CTRL) mdl[a] = v;
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic rchk;
    foreach (mdl[a]) begin
      rd(a);
      chk("reg", d, {24'h0, mdl[a]});
      chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    end
  endtask
  task automatic ochk;
    logic [2:0] c, e;
    logic b;
    repeat (2) @(posedge clk);
    c = mdl[ADDR_VCO_DIV][2:0];
    e = (c == 3'h1) ? 3'h0 : (c > 3'h1 && c < 3'h6) ? c : 3'h1;
    b = mdl[ADDR_DIST_SRC][0];
    chk("pwrdn", pd, mdl[ADDR_PLL_CTRL][1:0] != 2'h0);
    chk("pol", pol, mdl[ADDR_PLL_CTRL][7]);
    chk("bypass", byp, b);
    chk("srcsel", sel, !mdl[ADDR_DIST_SRC][1]);
    chk("ratio", rat, e);
    chk("presc", pre, mdl[ADDR_PLL_CTRL][1:0] == 2'h0 && !mdl[ADDR_DIST_SRC][1]);
    chk("limit", ok, 2000 <= 1600 * (b ? 1 : int'(e) + 1));
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS);
      n++;
    end while (d[b] !== 1'b1 && n < 40);
    chk("status", d[b], 1'b1);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    mdl[ADDR_PLL_CTRL] = 8'h01;
    mdl[ADDR_VCO_DIV] = 8'h00;
    mdl[ADDR_DIST_SRC] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ochk();
    rchk();
    rd(ADDR_STATUS);
    chk("status_rst", d, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic end_sim;
    $display("counts: run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h05EA));
    do_reset();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_PLL_CTRL, {i[2], 5'($urandom()), i[1:0]}, 4'hF);
      wr(ADDR_VCO_DIV, {5'($urandom()), i[2:0]}, 4'hF);
      wr(ADDR_DIST_SRC, {6'($urandom()), i[1:0]}, 4'h1);
      ochk();
      rchk();
    end
    $display("test fields done");
    wr(ADDR_VCO_DIV, 8'h03, 4'hE);
    wr(12'h020, 8'h5A, 4'hF);
    rchk();
    rd(12'h020);
    chk("unmapped", d, 32'h0);
    chk("unm_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test refusals done");
    wr(ADDR_PLL_CTRL, 8'h80, 4'hF);
    wr(ADDR_DIST_SRC, 8'h01, 4'hF);
    snap = mdl;
    wr(ADDR_NV_CTRL, 8'h01, 4'hF);
    poll(2);
    wr(ADDR_PLL_CTRL, 8'h01, 4'hF);
    wr(ADDR_DIST_SRC, 8'h02, 4'hF);
    wr(ADDR_NV_CTRL, 8'h02, 4'hF);
    poll(3);
    mdl = snap;
    rchk();
    ochk();
    rd(ADDR_STATUS);
    chk("status_load", d, 32'h0000000C);
    rd(ADDR_NV_CTRL);
    chk("nvctl_rd", d, 32'h00000000);
    chk("nvctl_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    $display("test nv done");
    do_reset();
    end_sim();
  end
endmodule
`default_nettype wire
